// >>> agc_pkg.sv
package agc_pkg;
    localparam int unsigned SAMPLE_W        = 16;
    localparam int unsigned PERIOD_W        = 3;
    // unity gain, q1.15 fixed point
    localparam logic [15:0] GAIN_RESET      = 16'h8000;
    localparam logic [15:0] OFFSET_RESET    = 16'h0000;
    // significant-bit mask for setting 0
    localparam logic [15:0] MASK_RESET      = 16'hfe00;
    localparam int unsigned GAIN_FRAC_BITS  = 15;
    // analogue transfer anchors of the core model, then the result clamp limits
    localparam logic [15:0] CODE_GROUND     = 16'he000;
    localparam logic [15:0] CODE_HALF_REF   = 16'h0000;
    localparam logic [15:0] CODE_REF        = 16'h2000;
    localparam logic [15:0] CODE_MAX        = 16'h7fff;
    localparam logic [15:0] CODE_MIN        = 16'h8000;
    // conversion time at setting 0, in ns
    localparam int unsigned CONV_NS_1MHZ    = 32000;
    localparam int unsigned CONV_NS_6MHZ    = 5333;
    localparam int unsigned CLK_NS          = 40;
    localparam int unsigned CONV_CYC_1MHZ   = CONV_NS_1MHZ / CLK_NS;
    localparam int unsigned CONV_CYC_6MHZ   = CONV_NS_6MHZ / CLK_NS;
    localparam int unsigned SIG_BITS_BASE   = 7;
    localparam int unsigned CNT_W           = 18;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } agc_sample_s;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             busy;
        logic [15:0]      raw;
        agc_sample_s      res;
        logic [15:0]      mask;
        logic             sat;
    } agc_state_s;
endpackage

// >>> agc_core.sv
// Operation
// [RULE1] results are signed sixteen-bit two's complement
// [RULE2] gain unsigned q1.15, reset means unity
// [RULE3] offset signed sixteen-bit added after gain
// [RULE4] software gain from reference and ground
// [RULE5] software offset from ground code
// [RULE6] ground sampled after gain is applied
// [RULE7] ground input converts near 0xe000
// [RULE8] no ground sample with buffer enabled
// [RULE9] reference near 0x2000, half reference near 0
// [RULE10] 1 MHz period doubles from 32 us
// [RULE11] 6 MHz period doubles from 5.33 us
// [RULE12] significant bits grow one per step
// [RULE13] multiply, add offset, clamp result
// [RULE14] gain overflow raises saturation flag
module agc_core
    import agc_pkg::*;
#(
    parameter int unsigned CYC_1MHZ = CONV_CYC_1MHZ,
    parameter int unsigned CYC_6MHZ = CONV_CYC_6MHZ
) (
    input  wire logic                ref_clk_i,
    input  wire logic                rst_i,
    input  wire logic                start_i,
    input  wire logic [PERIOD_W-1:0] period_i,
    input  wire logic                fast_clk_i,
    input  wire logic [15:0]         raw_sample_i,
    input  wire logic [15:0]         gain_i,
    input  wire logic [15:0]         offset_i,
    output logic                     busy_o,
    output agc_sample_s              result_o,
    output logic [15:0]              sig_mask_o,
    output logic                     gain_saturation_flag_o
);
    agc_state_s s_q;
    agc_state_s s_d;

    function automatic logic [CNT_W-1:0] conv_cycles(input logic [PERIOD_W-1:0] p,
                                                      input logic f);
        logic [CNT_W-1:0] base;
        // 6 MHz base is truncated, so long fast periods run slightly short
        base = f ? CNT_W'(CYC_6MHZ) : CNT_W'(CYC_1MHZ);
        return base << p;
    endfunction

    // seven significant bits at setting 0, one more per step
    function automatic logic [15:0] sig_mask(input logic [PERIOD_W-1:0] p);
        logic [4:0] drop;
        drop = 5'(SAMPLE_W - SIG_BITS_BASE) - 5'(p);
        return 16'hffff << drop;
    endfunction

    // clamp a wide signed value to sixteen bits
    function automatic logic [15:0] clamp16(input logic signed [33:0] v);
        if (v > 34'sd32767) begin
            return CODE_MAX;
        end else if (v < -34'sd32768) begin
            return CODE_MIN;
        end
        return v[15:0];
    endfunction

    // 34 bits cover a 16 x 17 signed product with headroom
    logic signed [33:0] prod;
    logic signed [33:0] gained;
    logic signed [33:0] summed;
    logic [15:0]        gclamp;
    logic               gsat;

    always_comb begin
        // [RULE2] unsigned gain scaling
        prod   = 34'(signed'(s_q.raw)) * signed'({18'h0, gain_i});
        gained = prod >>> GAIN_FRAC_BITS;
        // [RULE14] overflow detect
        gsat   = (gained > 34'sd32767) || (gained < -34'sd32768);
        gclamp = clamp16(gained);
        // [RULE3] signed offset add
        summed = 34'(signed'(gclamp)) + 34'(signed'(offset_i));
    end

    always_comb begin
        s_d = s_q;
        s_d.res.valid = 1'b0;
        s_d.sat = 1'b0;
        // [RULE12] top 7+period bits kept
        s_d.mask = sig_mask(period_i);
        if (!s_q.busy && start_i) begin
            s_d.busy = 1'b1;
            // [RULE10] [RULE11] doubling period
            s_d.cnt  = conv_cycles(period_i, fast_clk_i) - CNT_W'(1);
            // [RULE7] [RULE9] core code truncated to precision
            s_d.raw  = raw_sample_i & s_d.mask;
        end else if (s_q.busy) begin
            if (s_q.cnt == '0) begin
                s_d.busy = 1'b0;
                s_d.res.valid = 1'b1;
                // [RULE13] [RULE1] clamped corrected result
                s_d.res.data = clamp16(summed);
                s_d.sat = gsat;
            end else begin
                s_d.cnt = s_q.cnt - CNT_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            s_q <= '{
                cnt:  '0,
                busy: 1'b0,
                raw:  16'h0000,
                res:  '{valid: 1'b0, data: 16'h0000},
                mask: MASK_RESET,
                sat:  1'b0
            };
        end else begin
            s_q <= s_d;
        end
    end

    assign busy_o = s_q.busy;
    assign result_o = s_q.res;
    assign sig_mask_o = s_q.mask;
    assign gain_saturation_flag_o = s_q.sat;

    // helper for the timing checks only
    int unsigned wait_cnt;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !s_q.busy) begin
            wait_cnt <= 0;
        end else begin
            wait_cnt <= wait_cnt + 1;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    // timing, counted from the cycle after the start edge
    conv_time_a: assert property ( // [RULE10]
        result_o.valid
        |-> $past(wait_cnt) + 1 == conv_cycles($past(period_i, 2), $past(fast_clk_i, 2))
        || $past(period_i, 2) != period_i)
        else $error("conversion length wrong");
    conv_slow_a: assert property ( // [RULE10]
        result_o.valid && !$past(fast_clk_i, 2) && $past(period_i, 2) == period_i
        |-> $past(wait_cnt) + 1 == (CYC_1MHZ << period_i))
        else $error("slow conversion length wrong");
    conv_fast_a: assert property ( // [RULE11]
        result_o.valid && $past(fast_clk_i, 2) && $past(period_i, 2) == period_i
        |-> $past(wait_cnt) + 1 == (CYC_6MHZ << period_i))
        else $error("fast conversion length wrong");
    start_busy_a: assert property ( // [RULE11]
        !busy_o && start_i |=> busy_o) else $error("start not taken");
    mask_a: assert property ( // [RULE12]
        ##1 sig_mask_o == (16'hffff << (5'd9 - 5'($past(period_i))))) else $error("mask wrong");
    unity_a: assert property ( // [RULE2]
        busy_o && s_q.cnt == '0 && gain_i == GAIN_RESET && offset_i == 16'h0000
        |=> result_o.data == $past(s_q.raw)) else $error("unity gain altered data");
    offset_a: assert property ( // [RULE3]
        busy_o && s_q.cnt == '0 && !gsat && summed == 34'(signed'(summed[15:0]))
        |=> result_o.data == $past(summed[15:0])) else $error("offset not added");
    clamp_hi_a: assert property ( // [RULE13]
        busy_o && s_q.cnt == '0 && summed > 34'sd32767 |=> result_o.data == CODE_MAX)
        else $error("upper clamp failed");
    clamp_lo_a: assert property ( // [RULE1]
        busy_o && s_q.cnt == '0 && summed < -34'sd32768 |=> result_o.data == CODE_MIN)
        else $error("lower clamp failed");
    sat_flag_a: assert property ( // [RULE14]
        gain_saturation_flag_o |-> result_o.valid && $past(gsat)) else $error("bad saturation");
    // mask follows period_i, so truncation is only checked at the start edge
    raw_mask_a: assert property ( // [RULE7]
        $rose(busy_o) |-> (s_q.raw & ~sig_mask_o) == 16'h0000)
        else $error("raw not truncated");
    start_raw_a: assert property ( // [RULE9]
        !busy_o && start_i
        |=> s_q.raw == ($past(raw_sample_i) & sig_mask_o))
        else $error("raw sample not captured");
    raw_hold_a: assert property ( // [RULE13]
        busy_o |=> $stable(s_q.raw)) else $error("raw changed during conversion");
    count_down_a: assert property ( // [RULE10]
        busy_o && s_q.cnt != '0
        |=> busy_o && s_q.cnt == $past(s_q.cnt) - CNT_W'(1))
        else $error("conversion counter skipped");

    // result handshake
    valid_pulse_a: assert property ( // [RULE13]
        result_o.valid |=> !result_o.valid) else $error("valid held too long");
    data_hold_a: assert property ( // [RULE1]
        !result_o.valid |-> $stable(result_o.data)) else $error("result changed without valid");
    busy_end_a: assert property ( // [RULE10]
        result_o.valid |-> !busy_o && $past(busy_o)) else $error("valid without conversion end");
    idle_quiet_a: assert property ( // [RULE13]
        !$past(busy_o) |-> !result_o.valid) else $error("valid while idle");

    // arithmetic corners and mask width
    zero_gain_a: assert property ( // [RULE2]
        busy_o && s_q.cnt == '0 && gain_i == 16'h0000
        |=> result_o.data == $past(offset_i))
        else $error("zero gain did not yield offset");
    sat_hi_a: assert property ( // [RULE14]
        busy_o && s_q.cnt == '0 && gsat && !s_q.raw[15]
        |-> gclamp == CODE_MAX) else $error("positive gain overflow not clamped");
    sat_lo_a: assert property ( // [RULE14]
        busy_o && s_q.cnt == '0 && gsat && s_q.raw[15]
        |-> gclamp == CODE_MIN) else $error("negative gain overflow not clamped");
    mask_width_a: assert property ( // [RULE12]
        ##1 $countones(sig_mask_o) == SIG_BITS_BASE + $past(period_i))
        else $error("mask width wrong");

    // reset is checked with its own clocking, outside the default disable
    reset_idle_a: assert property ( // [RULE12]
        @(posedge ref_clk_i) disable iff (1'b0)
        $past(rst_i) |-> !busy_o && !result_o.valid && sig_mask_o == MASK_RESET)
        else $error("state not cleared by reset");

    conv_done_c: cover property (result_o.valid);
    sat_c: cover property (gain_saturation_flag_o);
    fast_c: cover property (fast_clk_i && start_i && !busy_o);
    long_c: cover property (period_i == 3'd7 && start_i && !busy_o);
    zero_gain_c: cover property (busy_o && s_q.cnt == '0 && gain_i == 16'h0000);
endmodule

// >>> agc_core_model.sv
module agc_core_model
    import agc_pkg::*;
(
    input  wire logic [1:0]  sel_i,
    input  wire logic [15:0] ext_i,
    output logic      [15:0] raw_o
);
    always_comb begin
        case (sel_i)
            2'h0:    raw_o = CODE_GROUND;
            2'h1:    raw_o = CODE_HALF_REF;
            2'h2:    raw_o = CODE_REF;
            default: raw_o = ext_i;
        endcase
    end
endmodule

// >>> adc_gain_offset_correction_test.sv
module adc_gain_offset_correction_test import agc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst = 1, start = 0, fast = 0, busy, sat;
    logic [2:0]  per = '0;
    logic [1:0]  sel = '0;
    logic [15:0] ext = '0, gain = GAIN_RESET, ofs = OFFSET_RESET, raw, mask, cal_g, cal_o;
    agc_sample_s res;
    int          err_total = 0, checks_done = 0;
    always #20 clk = ~clk;
    agc_core_model u_core (.sel_i(sel), .ext_i(ext), .raw_o(raw));
    // short counts keep the run brief; distinct so the two rates differ
    agc_core #(.CYC_1MHZ(4), .CYC_6MHZ(2)) u_dut (.ref_clk_i(clk), .rst_i(rst),
        .start_i(start), .period_i(per), .fast_clk_i(fast), .raw_sample_i(raw),
        .gain_i(gain), .offset_i(ofs), .busy_o(busy), .result_o(res),
        .sig_mask_o(mask), .gain_saturation_flag_o(sat));
    task chk(input logic [19:0] seen, input logic [19:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    function automatic logic [16:0] expect_f(logic [15:0] r, g, o, logic [2:0] p);
        logic signed [33:0] m;
        logic signed [17:0] s;
        logic               v;
        m = $signed(r & (16'hffff << (9 - p))) * $signed({1'b0, g});
        m = m >>> 15;
        v = m > 34'sd32767 || m < -34'sd32768;
        s = v ? (m[33] ? -18'sd32768 : 18'sd32767) : m[17:0];
        s = s + $signed(o);
        if (s > 18'sd32767) s = 18'sd32767;
        if (s < -18'sd32768) s = -18'sd32768;
        return {v, s[15:0]};
    endfunction
    task conv(input logic [1:0] sl, input logic [15:0] x, g, o, input logic [2:0] p,
              input logic f);
        int          k;
        logic [15:0] r;
        @(posedge clk);
        {sel, ext, gain, ofs, per, fast} <= {sl, x, g, o, p, f};
        start <= 1'b1;
        @(posedge clk);
        r = raw;
        start <= 1'b0;
        k = 0;
        do begin
            @(posedge clk);
            #1 k++;
        end while (res.valid !== 1'b1 && k < 2000);
        chk(20'(k), 20'((f ? 2 : 4) << p));
        chk({busy, mask}, {1'b0, 16'hffff << (9 - p)});
        chk({sat, res.data}, expect_f(r, g, o, p));
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #1 chk({busy, res.valid, sat, mask}, {3'b000, 16'hfe00});
        @(posedge clk);
        rst <= 1'b0;
        for (int p = 0; p < 8; p++) conv(2'(p % 3), '0, GAIN_RESET, OFFSET_RESET, 3'(p), p[0]);
        conv(2'h3, 16'h7000, 16'hffff, 16'h0000, 3'h7, 1'b0);
        conv(2'h3, 16'h8000, 16'hffff, 16'h0001, 3'h7, 1'b1);
        conv(2'h3, 16'h8000, 16'h8000, 16'h8000, 3'h7, 1'b1);
        conv(2'h3, 16'h7ffc, 16'h0000, 16'h7fff, 3'h6, 1'b0);
        // buffer stays off, ground is reachable
        conv(2'h2, '0, GAIN_RESET, OFFSET_RESET, 3'h4, 1'b1);
        cal_g = res.data;
        conv(2'h0, '0, GAIN_RESET, OFFSET_RESET, 3'h4, 1'b1);
        // gain from reference and ground slope
        cal_g = 16'(32768 * 16384 / (int'($signed(cal_g)) - int'($signed(res.data))));
        // ground retaken with new gain active
        conv(2'h0, '0, cal_g, OFFSET_RESET, 3'h4, 1'b1);
        cal_o = 16'(2 * (57344 - int'(res.data)));
        conv(2'h0, '0, cal_g, cal_o, 3'h4, 1'b1);
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        wrap_up();
    end
endmodule
